// file: core/regulator_voltage_monitor.sv
// digital control of over and under voltage supervisors of seven regulators
// Summary of operation
// R1 - separate low and high supervision, seven regulators
// R2 - low trip code picks 95/93/91/89 percent
// R3 - high trip code picks 105/107/109/111 percent
// R4 - shared low debounce: 5/15/25/40 us
// R5 - low debounce field resets to 10
// R6 - shared high debounce, four durations
// R7 - high debounce field resets to 00
// R8 - per regulator enable bit gates supervision
// R9 - all enable bits start at one
// R10 - secure sequence needed to change enables
// R11 - mask faults until regulator reaches regulation
// R12 - disabled monitor forces both flags low
// R13 - high debounce codes map 30/50/80/125 us
// R14 - debounce counted on 100 kHz tick
// R15 - flag only after condition persists through the chosen number of slow ticks
// R16 - masked monitor holds its counter cleared
`timescale 1ns/1ps
`include "vmon_defs.svh"
module regulator_voltage_monitor #(
	parameter int NREG = 7,
	parameter int CW   = 4
) (
	input  wire logic            SYS_CLK,
	input  wire logic            RESETN,
	input  wire logic [NREG-1:0] LOW_CMP,
	input  wire logic [NREG-1:0] HIGH_CMP,
	input  wire logic [NREG-1:0] REG_ON,
	input  wire logic [NREG-1:0] REG_IN_REGULATION,
	input  wire logic [9:0]      SWITCHER_LOW_TRIP_SELECT,
	input  wire logic [3:0]      LINEAR_LOW_TRIP_SELECT,
	input  wire logic [9:0]      SWITCHER_HIGH_TRIP_SELECT,
	input  wire logic [3:0]      LINEAR_HIGH_TRIP_SELECT,
	input  wire logic [7:0]      AWADDR,
	input  wire logic            AWVALID,
	output logic                 AWREADY,
	input  wire logic [31:0]     WDATA,
	input  wire logic [3:0]      WSTRB,
	input  wire logic            WVALID,
	output logic                 WREADY,
	output logic [1:0]           BRESP,
	output logic                 BVALID,
	input  wire logic            BREADY,
	input  wire logic [7:0]      ARADDR,
	input  wire logic            ARVALID,
	output logic                 ARREADY,
	output logic [31:0]          RDATA,
	output logic [1:0]           RRESP,
	output logic                 RVALID,
	input  wire logic            RREADY,
	output logic [NREG-1:0]      LOW_TRIP_STATUS,
	output logic [NREG-1:0]      HIGH_TRIP_STATUS,
	output logic [NREG-1:0]      SUPERVISOR_ENABLE,
	output logic [2*NREG-1:0]    LOW_TRIP_CODE,
	output logic [2*NREG-1:0]    HIGH_TRIP_CODE,
	output logic                 IRQ
);
	localparam int SW = 4*NREG + 28; // width of the pin synchroniser

	logic [SW-1:0]       sync1_q;    // first synchroniser stage
	logic [SW-1:0]       sync2_q;    // second synchroniser stage
	logic [NREG-1:0]     low_s;      // synced low comparator
	logic [NREG-1:0]     high_s;     // synced high comparator
	logic [NREG-1:0]     on_s;       // synced regulator on
	logic [NREG-1:0]     inreg_s;    // synced in regulation
	logic [NREG-1:0]     on_prev_q;  // regulator on, one cycle late
	logic [NREG-1:0]     mask_q;     // start-up mask per regulator
	logic [6:0]          tick_cnt_q; // slow tick divider
	logic                tick_q;     // one pulse per slow period
	vmon_pkg::db_sel_t   low_db_q;   // shared low debounce select
	vmon_pkg::db_sel_t   high_db_q;  // shared high debounce select
	logic                sec_en_q;   // secure access enable
	logic                armed_q;    // key written, one secure write allowed
	logic [NREG-1:0]     sup_en_q;   // per regulator supervisor enable
	logic [CW-1:0]       low_lim;    // low debounce limit in ticks
	logic [CW-1:0]       high_lim;   // high debounce limit in ticks
	logic [NREG-1:0]     low_stat;   // debounced low flags
	logic [NREG-1:0]     high_stat;  // debounced high flags
	logic [NREG-1:0]     low_prev_q; // low flags, one cycle late
	logic [NREG-1:0]     high_prev_q;// high flags, one cycle late
	logic [14:0]         irq_sts_q;  // sticky event bits
	logic [14:0]         irq_en_q;   // event enables
	logic [14:0]         irq_set;    // events this cycle
	logic [14:0]         irq_sts_d;  // next sticky bits
	logic [14:0]         irq_clr;    // bits cleared by software
	logic [14:0]         irq_en_d;   // next event enables
	vmon_pkg::ch_state_e wr_st_q;    // write channel state
	vmon_pkg::ch_state_e rd_st_q;    // read channel state
	logic                wr_fire;    // write address and data taken
	logic                rd_fire;    // read address taken
	logic [31:0]         wmask;      // byte lane mask of this write
	logic [31:0]         rd_d;       // read data mux
	logic                rd_ok;      // read address is mapped
	logic                wr_ok;      // write address is mapped

	// every comparator, regulator and trip select pin passes two flip-flops before use; the bus pins are used directly
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {LINEAR_HIGH_TRIP_SELECT, SWITCHER_HIGH_TRIP_SELECT,
				LINEAR_LOW_TRIP_SELECT, SWITCHER_LOW_TRIP_SELECT,
				REG_IN_REGULATION, REG_ON, HIGH_CMP, LOW_CMP};
			sync2_q <= sync1_q;
		end
	end
	assign low_s   = sync2_q[NREG-1:0];
	assign high_s  = sync2_q[2*NREG-1:NREG];
	assign on_s    = sync2_q[3*NREG-1:2*NREG];
	assign inreg_s = sync2_q[4*NREG-1:3*NREG];

	// trip level codes to the analog references, switchers low, linears high
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			LOW_TRIP_CODE  <= '0;
			HIGH_TRIP_CODE <= '0;
		end else begin
			LOW_TRIP_CODE  <= sync2_q[4*NREG +: 2*NREG];  // see R2
			HIGH_TRIP_CODE <= sync2_q[6*NREG +: 2*NREG];  // see R3
		end
	end

	// slow debounce tick from the system clock
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == 7'(`VMON_TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1; // see R14
		end else begin
			tick_cnt_q <= tick_cnt_q + 7'h01;
			tick_q     <= 1'b0;
		end
	end

	// start-up mask: off, or on but not yet in regulation
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			on_prev_q <= '0;
			mask_q    <= '1;
		end else begin
			on_prev_q <= on_s;
			mask_q    <= ~on_s | ((mask_q | (on_s & ~on_prev_q)) & ~inreg_s); // see R11
		end
	end

	// debounce limits from the shared selects
	always_comb begin
		case (low_db_q)
			2'b00:   low_lim = CW'(`VMON_TICKS(`VMON_UV_DB0_US)); // see R4
			2'b01:   low_lim = CW'(`VMON_TICKS(`VMON_UV_DB1_US));
			2'b10:   low_lim = CW'(`VMON_TICKS(`VMON_UV_DB2_US));
			default: low_lim = CW'(`VMON_TICKS(`VMON_UV_DB3_US));
		endcase
		case (high_db_q)
			2'b00:   high_lim = CW'(`VMON_TICKS(`VMON_OV_DB0_US)); // see R6, see R13
			2'b01:   high_lim = CW'(`VMON_TICKS(`VMON_OV_DB1_US));
			2'b10:   high_lim = CW'(`VMON_TICKS(`VMON_OV_DB2_US));
			default: high_lim = CW'(`VMON_TICKS(`VMON_OV_DB3_US));
		endcase
	end

	// two debounced supervisors per regulator
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_mon
			// low trip supervisor, cleared when masked or disabled
			vmon_debounce #(.CW(CW)) u_low (
				.clk    (SYS_CLK),
				.rst_n  (RESETN),
				.cond   (low_s[gi]),
				.clr    (mask_q[gi] | ~sup_en_q[gi]), // see R1, see R8, see R12
				.tick   (tick_q),
				.limit  (low_lim),
				.flag_q (low_stat[gi])
			);
			// high trip supervisor, same gating
			vmon_debounce #(.CW(CW)) u_high (
				.clk    (SYS_CLK),
				.rst_n  (RESETN),
				.cond   (high_s[gi]),
				.clr    (mask_q[gi] | ~sup_en_q[gi]), // see R1, see R8, see R12
				.tick   (tick_q),
				.limit  (high_lim),
				.flag_q (high_stat[gi])
			);
		end
	endgenerate
	assign LOW_TRIP_STATUS  = low_stat;
	assign HIGH_TRIP_STATUS = high_stat;
	assign SUPERVISOR_ENABLE = sup_en_q;

	// bus handshakes: write needs address and data both offered
	assign wr_fire = AWVALID & WVALID & AWREADY;
	assign rd_fire = ARVALID & ARREADY;
	assign wmask   = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};

	// write address decode
	always_comb begin
		if (AWADDR == `VMON_CTRL_OFS) begin
			wr_ok = 1'b1;
		end else if (AWADDR == `VMON_SUP_EN_OFS) begin
			wr_ok = 1'b1;
		end else if (AWADDR == `VMON_KEY_OFS) begin
			wr_ok = 1'b1;
		end else if (AWADDR == `VMON_IRQ_CLR_OFS) begin
			wr_ok = 1'b1;
		end else if (AWADDR == `VMON_IRQ_EN_OFS) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	// write channel: take both, answer one cycle later
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			wr_st_q <= vmon_pkg::CH_IDLE;
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			BVALID  <= 1'b0;
			BRESP   <= vmon_pkg::RESP_OKAY;
		end else begin
			case (wr_st_q)
				vmon_pkg::CH_IDLE: begin
					AWREADY <= AWVALID & WVALID & ~AWREADY;
					WREADY  <= AWVALID & WVALID & ~AWREADY;
					if (wr_fire) begin
						AWREADY <= 1'b0;
						WREADY  <= 1'b0;
						BVALID  <= 1'b1;
						BRESP   <= wr_ok ? vmon_pkg::RESP_OKAY : vmon_pkg::RESP_SLVERR;
						wr_st_q <= vmon_pkg::CH_RESP;
					end
				end
				default: begin
					if (BREADY) begin
						BVALID  <= 1'b0;
						wr_st_q <= vmon_pkg::CH_IDLE;
					end
				end
			endcase
		end
	end

	// control fields and secure unlock
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			low_db_q  <= `VMON_LOW_TRIP_DEBOUNCE_SELECT_RST; // see R5
			high_db_q <= `VMON_HIGH_TRIP_DEBOUNCE_SELECT_RST; // see R7
			sec_en_q  <= `VMON_SEC_EN_RST;
			armed_q   <= 1'b0;
		end else if (wr_fire) begin
			// any write other than the key disarms the unlock
			armed_q <= 1'b0;
			if (AWADDR == `VMON_CTRL_OFS && WSTRB[0]) begin
				low_db_q  <= WDATA[`VMON_LOW_TRIP_DEBOUNCE_SELECT_LSB +: 2];
				high_db_q <= WDATA[`VMON_HIGH_TRIP_DEBOUNCE_SELECT_LSB +: 2];
				sec_en_q  <= WDATA[`VMON_SEC_EN_BIT];
			end else if (AWADDR == `VMON_KEY_OFS) begin
				armed_q <= (WDATA == `VMON_SECURE_KEY) && (WSTRB == 4'hf); // see R10
			end
		end
	end

	// supervisor enables, guarded while secure access is on
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sup_en_q <= `VMON_SUP_EN_RST; // see R9
		end else if (wr_fire && AWADDR == `VMON_SUP_EN_OFS && WSTRB[0]) begin
			if (!sec_en_q || armed_q) begin
				sup_en_q <= WDATA[NREG-1:0]; // see R8, see R10
			end
		end
	end

	// events: a status flag rising
	assign irq_set = {high_stat & ~high_prev_q, 1'b0, low_stat & ~low_prev_q};
	assign irq_clr = (wr_fire && AWADDR == `VMON_IRQ_CLR_OFS) ? (WDATA[14:0] & wmask[14:0]) : '0;
	// set wins over a clear in the same cycle
	assign irq_sts_d = (irq_sts_q & ~irq_clr) | irq_set;
	// enables as they stand after this edge, so the line never lags a new enable
	assign irq_en_d = (wr_fire && AWADDR == `VMON_IRQ_EN_OFS) ?
		((irq_en_q & ~wmask[14:0]) | (WDATA[14:0] & wmask[14:0])) : irq_en_q;

	// sticky events, enables and the interrupt line
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			low_prev_q  <= '0;
			high_prev_q <= '0;
			irq_sts_q   <= '0;
			irq_en_q    <= '0;
			IRQ         <= 1'b0;
		end else begin
			low_prev_q  <= low_stat;
			high_prev_q <= high_stat;
			irq_sts_q   <= irq_sts_d;
			IRQ         <= |(irq_sts_d & irq_en_d);
			irq_en_q    <= irq_en_d;
		end
	end

	// read address decode and data
	always_comb begin
		rd_d  = '0;
		rd_ok = 1'b1;
		if (ARADDR == `VMON_CTRL_OFS) begin
			rd_d[`VMON_LOW_TRIP_DEBOUNCE_SELECT_LSB +: 2] = low_db_q;
			rd_d[`VMON_HIGH_TRIP_DEBOUNCE_SELECT_LSB +: 2] = high_db_q;
			rd_d[`VMON_SEC_EN_BIT]     = sec_en_q;
		end else if (ARADDR == `VMON_SUP_EN_OFS) begin
			rd_d[NREG-1:0] = sup_en_q;
		end else if (ARADDR == `VMON_KEY_OFS) begin
			rd_d[0] = armed_q;
		end else if (ARADDR == `VMON_STATUS_OFS) begin
			rd_d[NREG-1:0]                  = low_stat;
			rd_d[`VMON_HIGH_LSB +: NREG]    = high_stat;
		end else if (ARADDR == `VMON_IRQ_STS_OFS) begin
			rd_d[14:0] = irq_sts_q;
		end else if (ARADDR == `VMON_IRQ_CLR_OFS) begin
			rd_d = '0;
		end else if (ARADDR == `VMON_IRQ_EN_OFS) begin
			rd_d[14:0] = irq_en_q;
		end else if (ARADDR == `VMON_MASK_OFS) begin
			rd_d[NREG-1:0] = mask_q;
		end else if (ARADDR == `VMON_TRIP_OFS) begin
			rd_d[2*NREG-1:0]                   = LOW_TRIP_CODE;
			rd_d[`VMON_TRIP_HI_LSB +: 2*NREG]  = HIGH_TRIP_CODE;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// read channel: take address, present data one cycle later
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rd_st_q <= vmon_pkg::CH_IDLE;
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= vmon_pkg::RESP_OKAY;
		end else begin
			case (rd_st_q)
				vmon_pkg::CH_IDLE: begin
					ARREADY <= ARVALID & ~ARREADY;
					if (rd_fire) begin
						ARREADY <= 1'b0;
						RVALID  <= 1'b1;
						RDATA   <= rd_d;
						RRESP   <= rd_ok ? vmon_pkg::RESP_OKAY : vmon_pkg::RESP_SLVERR;
						rd_st_q <= vmon_pkg::CH_RESP;
					end
				end
				default: begin
					if (RREADY) begin
						RVALID  <= 1'b0;
						rd_st_q <= vmon_pkg::CH_IDLE;
					end
				end
			endcase
		end
	end

	// debounce fields come out of reset at their defaults
	property p_db_reset;
		@(posedge SYS_CLK) $rose(RESETN) |-> (low_db_q == 2'b10) && (high_db_q == 2'b00);
	endproperty
	a_db_reset: assert property (p_db_reset) else $error("debounce reset value wrong"); // see R5

	// all supervisors enabled after reset
	property p_en_reset;
		@(posedge SYS_CLK) $rose(RESETN) |-> (SUPERVISOR_ENABLE == 7'h7f);
	endproperty
	a_en_reset: assert property (p_en_reset) else $error("enables not all set"); // see R9

	// a locked enable write changes nothing
	property p_secure;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(wr_fire && AWADDR == `VMON_SUP_EN_OFS && sec_en_q && !armed_q) |=> $stable(sup_en_q);
	endproperty
	a_secure: assert property (p_secure) else $error("locked enable changed"); // see R10

	// disabled monitor shows no flags one cycle later
	property p_disable_clears;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(sup_en_q != 7'h7f) |=> (((low_stat | high_stat) & ~$past(sup_en_q)) == 7'h00);
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("flag on disabled"); // see R12

	// masked monitor shows no flags one cycle later
	property p_mask_clears;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(mask_q != 7'h00) |=> (((low_stat | high_stat) & $past(mask_q)) == 7'h00);
	endproperty
	a_mask_clears: assert property (p_mask_clears) else $error("flag while masked"); // see R11

	// the slow tick repeats every hundred system cycles
	property p_tick;
		@(posedge SYS_CLK) disable iff (!RESETN)
		tick_q |=> !tick_q [*8] ##92 tick_q;
	endproperty
	a_tick: assert property (p_tick) else $error("slow tick period wrong"); // see R14

	// the low flag of regulator 0 rises only after its condition held a while
	property p_low_persist;
		@(posedge SYS_CLK) disable iff (!RESETN)
		$rose(low_stat[0]) |-> $past(low_s[0]) && $past(low_s[0], 2) && !$past(mask_q[0]);
	endproperty
	a_low_persist: assert property (p_low_persist) else $error("low flag too early"); // see R15

	// the interrupt follows an enabled sticky bit
	property p_irq;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(|(irq_sts_q & irq_en_q)) |-> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

// file: core/vmon_debounce.sv
// one debounce counter for one supervisor comparator
`timescale 1ns/1ps
module vmon_debounce #(
	parameter int CW = 4
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          cond,
	input  wire logic          clr,
	input  wire logic          tick,
	input  wire logic [CW-1:0] limit,
	output logic               flag_q
);
	logic [CW-1:0] cnt_q; // slow ticks seen while condition holds

	// count ticks while the condition stands, restart on any drop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			flag_q <= 1'b0;
		end else if (clr || !cond) begin
			// masked, disabled or dropped: start over, flag low
			cnt_q  <= '0; // see R15, see R16
			flag_q <= 1'b0;
		end else if (tick && !flag_q) begin
			cnt_q <= cnt_q + 1'b1;
			// flag once the chosen number of ticks has passed
			if ((cnt_q + 1'b1) >= limit) begin
				flag_q <= 1'b1; // see R15
			end
		end
	end
endmodule

// file: include/vmon_defs.svh
// constants of the regulator voltage supervisor: offsets, fields, resets, timing
`ifndef VMON_DEFS_SVH
`define VMON_DEFS_SVH

// clock rates in kHz
`define VMON_SYS_CLK_KHZ 10000
`define VMON_LP_CLK_KHZ 100
// system clock cycles per slow debounce tick
`define VMON_TICK_CYCLES (`VMON_SYS_CLK_KHZ / `VMON_LP_CLK_KHZ)
// least time in us rounded up to whole slow ticks
`define VMON_TICKS(us) ((((us) * `VMON_LP_CLK_KHZ) + 999) / 1000)

// low trip debounce times in us
`define VMON_UV_DB0_US 5
`define VMON_UV_DB1_US 15
`define VMON_UV_DB2_US 25
`define VMON_UV_DB3_US 40
// high trip debounce times in us
`define VMON_OV_DB0_US 30
`define VMON_OV_DB1_US 50
`define VMON_OV_DB2_US 80
`define VMON_OV_DB3_US 125

// register byte offsets
`define VMON_CTRL_OFS     8'h00
`define VMON_SUP_EN_OFS   8'h04
`define VMON_KEY_OFS      8'h08
`define VMON_STATUS_OFS   8'h0c
`define VMON_IRQ_STS_OFS  8'h10
`define VMON_IRQ_CLR_OFS  8'h14
`define VMON_IRQ_EN_OFS   8'h18
`define VMON_MASK_OFS     8'h1c
`define VMON_TRIP_OFS     8'h20

// field positions
`define VMON_LOW_TRIP_DEBOUNCE_SELECT_LSB    0
`define VMON_HIGH_TRIP_DEBOUNCE_SELECT_LSB    2
`define VMON_SEC_EN_BIT   4
`define VMON_HIGH_LSB     8
`define VMON_TRIP_HI_LSB  16

// reset values
`define VMON_LOW_TRIP_DEBOUNCE_SELECT_RST    2'b10
`define VMON_HIGH_TRIP_DEBOUNCE_SELECT_RST    2'b00
`define VMON_SEC_EN_RST   1'b0
`define VMON_SUP_EN_RST   7'h7f
// unlock word for a secure write, arbitrary value
`define VMON_SECURE_KEY   32'h0000_5a5a

`endif

// file: include/vmon_pkg.sv
// types shared by the regulator voltage supervisor
package vmon_pkg;
	// debounce selection code
	typedef logic [1:0] db_sel_t;
	// bus answer codes
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_e;
	// bus channel state
	typedef enum logic {
		CH_IDLE = 1'b0,
		CH_RESP = 1'b1
	} ch_state_e;
endpackage

// file: tb/regulator_voltage_monitor_tb_top.sv
// self-checking bench of the regulator voltage supervisor
`timescale 1ns/1ps
`include "vmon_defs.svh"
module regulator_voltage_monitor_tb_top;
	logic        sys_clk;                  // 10 MHz system clock
	logic        rst_n;                    // async reset, active low
	logic [6:0]  low_cmp, high_cmp;        // comparator stimulus
	logic [6:0]  reg_on, reg_ok;           // regulator on and in regulation
	logic [7:0]  awaddr, araddr;           // bus addresses
	logic [31:0] wdata, rdata;             // bus data
	logic [3:0]  wstrb;                    // byte strobes
	logic        awvalid, wvalid, bready;  // write channel controls
	logic        arvalid, rready;          // read channel controls
	logic        awready, wready, bvalid;  // write channel answers
	logic        arready, rvalid, irq;     // read answers and interrupt
	logic [1:0]  bresp, rresp;             // response codes
	logic [6:0]  low_sts, high_sts, sup_en; // flags and enables
	logic [13:0] low_code, high_code;      // trip codes shown to analog
	logic [31:0] d;                        // read result
	logic [1:0]  r;                        // response result
	int          fails, n_tests;           // mismatch and comparison counts
	// static trip codes holding every code at least once
	localparam logic [9:0] SW_LO = 10'h393;
	localparam logic [3:0] LD_LO = 4'h6;
	localparam logic [9:0] SW_HI = 10'h0e4;
	localparam logic [3:0] LD_HI = 4'h9;
	localparam int UVN[4] = '{1, 2, 3, 4};  // low debounce in slow ticks
	localparam int OVN[4] = '{3, 5, 8, 13}; // high debounce in slow ticks

	regulator_voltage_monitor dut (.SYS_CLK(sys_clk), .RESETN(rst_n), .LOW_CMP(low_cmp),
		.HIGH_CMP(high_cmp), .REG_ON(reg_on), .REG_IN_REGULATION(reg_ok),
		.SWITCHER_LOW_TRIP_SELECT(SW_LO), .LINEAR_LOW_TRIP_SELECT(LD_LO),
		.SWITCHER_HIGH_TRIP_SELECT(SW_HI), .LINEAR_HIGH_TRIP_SELECT(LD_HI),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .LOW_TRIP_STATUS(low_sts),
		.HIGH_TRIP_STATUS(high_sts), .SUPERVISOR_ENABLE(sup_en), .LOW_TRIP_CODE(low_code),
		.HIGH_TRIP_CODE(high_code), .IRQ(irq));

	// clock generator, 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// one comparison
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	// a wait that ran out of its bound ends the run
	task automatic guard(input int k, input int lim);
		if (k >= lim) begin
			chk(1'b0, "timeout");
			stop_test();
		end
	endtask

	// bus write, both channels offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (awready !== 1'b1 && k < 50);
		guard(k, 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (bvalid !== 1'b1 && k < 50);
		guard(k, 50);
		rs = bresp;
		bready <= 1'b0;
	endtask

	// bus read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (arready !== 1'b1 && k < 50);
		guard(k, 50);
		arvalid <= 1'b0;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (rvalid !== 1'b1 && k < 50);
		guard(k, 50);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// selected flag of one regulator
	function automatic logic flg(input bit hi, input int i);
		return hi ? high_sts[i] : low_sts[i];
	endfunction

	// raise one comparator, time the flag against n slow ticks, then release it
	task automatic meas(input bit hi, input int i, input int n);
		int k;
		if (hi) high_cmp[i] <= 1'b1; else low_cmp[i] <= 1'b1;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (flg(hi, i) !== 1'b1 && k < n*100+20);
		guard(k, n*100+20);
		chk(k > (n-1)*100 && k <= n*100+5, "debounce time");
		if (hi) high_cmp[i] <= 1'b0; else low_cmp[i] <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(flg(hi, i) === 1'b0, "flag not released");
	endtask

	// reset values, unmapped access, trip codes
	task automatic t_reset();
		chk(sup_en === 7'h7f, "enable port reset");
		axi_rd(`VMON_CTRL_OFS, d, r);
		chk(d[4:0] === 5'h02, "ctrl reset");
		axi_rd(`VMON_SUP_EN_OFS, d, r);
		chk(d[6:0] === 7'h7f, "enable reg reset");
		axi_rd(8'h40, d, r);
		chk(r === vmon_pkg::RESP_SLVERR, "unmapped read");
		axi_wr(8'h40, 32'h0, r);
		chk(r === vmon_pkg::RESP_SLVERR, "unmapped write");
		chk(low_code === {LD_LO, SW_LO} && high_code === {LD_HI, SW_HI}, "codes");
		axi_rd(`VMON_TRIP_OFS, d, r);
		chk(d[13:0] === {LD_LO, SW_LO} && d[29:16] === {LD_HI, SW_HI}, "trip reg");
	endtask

	// every debounce code on both comparators, and a restart after a short drop
	task automatic t_debounce();
		for (int c = 0; c < 4; c++) begin
			axi_wr(`VMON_CTRL_OFS, 32'(c*4 + c), r);
			meas(1'b0, c, UVN[c]);
			meas(1'b1, c + 3, OVN[c]);
		end
		low_cmp[5] <= 1'b1;
		repeat (250) @(posedge sys_clk);
		low_cmp[5] <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(low_sts[5] === 1'b0, "early flag");
		meas(1'b0, 5, 4);
	endtask

	// start-up masking: off, ramping, then in regulation
	task automatic t_mask();
		int k;
		axi_wr(`VMON_CTRL_OFS, 32'h1, r);
		reg_on[1] <= 1'b0;
		reg_ok[1] <= 1'b0;
		low_cmp[1] <= 1'b1;
		repeat (400) @(posedge sys_clk);
		chk(low_sts[1] === 1'b0, "flag while off");
		reg_on[1] <= 1'b1;
		repeat (400) @(posedge sys_clk);
		chk(low_sts[1] === 1'b0, "flag while ramping");
		axi_rd(`VMON_MASK_OFS, d, r);
		chk(d[1] === 1'b1, "mask bit");
		reg_ok[1] <= 1'b1;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (low_sts[1] !== 1'b1 && k < 230);
		guard(k, 230);
		chk(k > 100 && k <= 206, "count not cleared by mask");
		low_cmp[1] <= 1'b0;
	endtask

	// enable bits, forced clear of flags, secure write
	task automatic t_enable();
		axi_wr(`VMON_CTRL_OFS, 32'h0, r);
		low_cmp[2] <= 1'b1;
		high_cmp[2] <= 1'b1;
		repeat (500) @(posedge sys_clk);
		chk(low_sts[2] === 1'b1 && high_sts[2] === 1'b1, "flags up");
		axi_rd(`VMON_STATUS_OFS, d, r);
		chk(d[2] === 1'b1 && d[10] === 1'b1 && r === vmon_pkg::RESP_OKAY, "status reg");
		axi_wr(`VMON_SUP_EN_OFS, 32'h7b, r);
		repeat (3) @(posedge sys_clk);
		chk(sup_en === 7'h7b && low_sts[2] === 1'b0 && high_sts[2] === 1'b0, "off");
		repeat (500) @(posedge sys_clk);
		chk(low_sts[2] === 1'b0, "flag while disabled");
		axi_wr(`VMON_CTRL_OFS, 32'h10, r);
		axi_wr(`VMON_SUP_EN_OFS, 32'h7f, r);
		chk(sup_en === 7'h7b, "unsecured change taken");
		axi_wr(`VMON_KEY_OFS, `VMON_SECURE_KEY, r);
		axi_wr(`VMON_SUP_EN_OFS, 32'h7f, r);
		repeat (2) @(posedge sys_clk);
		chk(sup_en === 7'h7f, "secure change lost");
		low_cmp[2] <= 1'b0;
		high_cmp[2] <= 1'b0;
		axi_wr(`VMON_CTRL_OFS, 32'h0, r);
	endtask

	// sticky status, enable, clear of the interrupt
	task automatic t_irq();
		axi_wr(`VMON_IRQ_CLR_OFS, 32'h7f7f, r);
		axi_wr(`VMON_IRQ_EN_OFS, 32'h1, r);
		chk(r === vmon_pkg::RESP_OKAY, "write response");
		repeat (3) @(posedge sys_clk);
		chk(irq === 1'b0, "irq idle");
		meas(1'b0, 0, 1);
		chk(irq === 1'b1, "irq missing");
		axi_rd(`VMON_IRQ_STS_OFS, d, r);
		chk(d[0] === 1'b1, "sticky bit");
		axi_wr(`VMON_IRQ_CLR_OFS, 32'h1, r);
		repeat (3) @(posedge sys_clk);
		chk(irq === 1'b0, "irq not cleared");
		meas(1'b0, 6, 1);
		chk(irq === 1'b0, "irq not masked");
		meas(1'b1, 4, 3);
		axi_rd(`VMON_IRQ_STS_OFS, d, r);
		chk(d[6] === 1'b1 && d[0] === 1'b0 && d[12] === 1'b1, "sticky layout");
	endtask

	// main sequence
	initial begin
		rst_n = 1'b0;
		low_cmp = 7'h00;
		high_cmp = 7'h00;
		reg_on = 7'h7f;
		reg_ok = 7'h7f;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		fails = 0;
		n_tests = 0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		t_reset();
		t_debounce();
		t_mask();
		t_enable();
		t_irq();
		stop_test();
	end
endmodule
